/* fir_wrap_pkg.sv */
// Constants, types and register map for the streaming filter wrapper
// What this block does
// - Transfers happen when valid and accept coincide
// - One lane sample per symbol, lanes per beat
// - Samples selectable as signed or unsigned
// - Source FIFO catches results after backpressure starts
// - Backpressure drops core advance, freezing the core
// - Core resumes once consumer accepts again
// - Ordinal one raises group first with valid
// - Ordinal equal packet size raises group last
// - Stall output high while consumer refuses data
// - Main clock, async active-low reset for control
// - Coefficient logic runs on its own clock
// - Coefficient logic has async active-high reset
// - Input accept high whenever data can be taken
// - Input valid low halts the filter
// - Slot index is log2 of channels per lane
// - Result bus lanes packed from bit zero upward
// - First means channel zero, last means final channel
// - Fault codes: none, no start, no end, other
// - Readback shows stored tap with read valid
// - Slot index counts zero to channels minus one
// - Slots per lane equal clock over sample rate
package fir_wrap_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] REG_CTRL   = 4'h0;  // Control: sample format
  localparam logic [3:0] REG_STATUS = 4'h4;  // Status: FIFO level, framing
  localparam logic [3:0] REG_INFO   = 4'h8;  // Geometry: slots, channels, lanes

  // Field positions
  localparam int CTRL_SIGNED_BIT = 0;   // Signed sample format select
  localparam int STAT_CNT_LSB    = 0;   // FIFO level field
  localparam int STAT_PKT_BIT    = 8;   // Inside a packet
  localparam int STAT_ERR_LSB    = 12;  // Last framing fault seen
  localparam int INFO_TDM_LSB    = 0;   // Time slots per lane
  localparam int INFO_CHAN_LSB   = 8;   // Channels per lane
  localparam int INFO_LANE_LSB   = 16;  // Output lane count

  // Reset values
  localparam logic       CTRL_SIGNED_RST = 1'h0;   // Unsigned after reset
  localparam logic [1:0] ERR_RST         = 2'h0;   // No fault recorded

  // Framing fault codes
  localparam logic [1:0] ERR_NONE     = 2'h0;  // No error
  localparam logic [1:0] ERR_NO_START = 2'h1;  // Missing start
  localparam logic [1:0] ERR_NO_END   = 2'h2;  // Missing end
  localparam logic [1:0] ERR_OTHER    = 2'h3;  // Ordinal zero or above packet size

  // Timing figures
  localparam int CLK_MHZ     = 100;  // Main clock rate in MHz
  localparam int SAMPLE_MSPS = 100;  // Per-channel sample rate in MSPS

  // Packet tracking on the source side
  typedef enum logic [0:0] {
    PKT_IDLE = 1'b0,  // Between packets
    PKT_BUSY = 1'b1   // Packet opened, last not yet seen
  } pkt_state_t;

endpackage : fir_wrap_pkg

/* fir_stream_wrapper.sv */
// Streaming wrapper, flow control and coefficient port around the filter core
`timescale 1ns/1ns
module fir_stream_wrapper #(
  parameter int DATA_W       = 8,   // Bits per sample symbol
  parameter int LANES        = 1,   // Output lane count
  parameter int CHANS        = 2,   // Channels per lane, also packet size
  parameter int COEF_W       = 16,  // Coefficient width
  parameter int NUM_COEF     = 8,   // Number of taps
  parameter int DEPTH        = 4,   // Source FIFO depth
  parameter int CORE_LAT     = 2,   // Core pipeline stages
  parameter int BACKPRESSURE = 1    // Backpressure support present
) (
  input  wire logic                          ref_clk_in,       // Main clock
  input  wire logic                          nrst_in,          // Async reset, low
  input  wire logic [3:0]                    reg_addr_in,      // Register address
  input  wire logic [31:0]                   reg_wdata_in,     // Register write data
  input  wire logic                          reg_wr_in,        // Register write strobe
  input  wire logic                          reg_rd_in,        // Register read strobe
  output logic      [31:0]                   reg_rdata_out,    // Read data, next cycle
  input  wire logic                          sink_valid_in,    // Input beat valid
  input  wire logic [DATA_W*LANES-1:0]       sink_data_in,     // Input samples
  input  wire logic [$clog2(CHANS+1):0]      sink_ordinal_in,  // Beat ordinal 1..CHANS
  output logic                               sink_ready_out,   // Input accept
  input  wire logic                          source_ready_in,  // Output accept
  output logic                               source_valid_out, // Output beat valid
  output logic      [DATA_W*LANES-1:0]       lane_result_out,  // Result bus
  output logic      [(CHANS>1 ? $clog2(CHANS) : 1)-1:0] source_channel_out, // Slot index
  output logic                               source_first_out, // Group first
  output logic                               source_last_out,  // Group last
  output logic      [1:0]                    source_error_out, // Framing fault
  output logic                               source_stall_out, // Stall request
  input  wire logic                          coef_clk_in,      // Coefficient clock
  input  wire logic                          coef_rst_in,      // Async reset, high
  input  wire logic [$clog2(NUM_COEF)-1:0]   coef_addr_in,     // Tap index
  input  wire logic                          coef_we_in,       // Tap write strobe
  input  wire logic [COEF_W-1:0]             coef_data_in,     // New tap value
  output logic                               coef_rvalid_out,  // Readback valid
  output logic      [COEF_W-1:0]             coef_rdata_out    // Readback value
);

  // Derived widths
  localparam int CH_W  = (CHANS > 1) ? $clog2(CHANS) : 1;
  localparam int ORD_W = $clog2(CHANS + 1) + 1;            // Ordinal width
  localparam int BUS_W = DATA_W * LANES;
  localparam int CNT_W = $clog2(DEPTH + 1);                // FIFO level width
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;  // FIFO pointer width
  localparam int CA_W  = $clog2(NUM_COEF);                 // Tap index width
  // Time slots per lane from clock and sample rate
  localparam int TDM   = fir_wrap_pkg::CLK_MHZ / fir_wrap_pkg::SAMPLE_MSPS;

  // One result beat with its ordinal
  typedef struct packed {
    logic [ORD_W-1:0] ord;   // Beat ordinal from producer
    logic [BUS_W-1:0] data;  // Lane samples
  } beat_t;

  // Whole state of the main domain
  typedef struct packed {
    logic                    signed_mode;  // Sample format
    logic                    sink_ready;   // Registered input accept
    logic                    stall;        // Registered stall
    logic [CORE_LAT-1:0]     pv;           // Core stage valid
    beat_t [CORE_LAT-1:0]    pipe;         // Core stages
    beat_t [DEPTH-1:0]       mem;          // FIFO storage
    logic [PTR_W-1:0]        wp;           // FIFO write pointer
    logic [PTR_W-1:0]        rp;           // FIFO read pointer
    logic [CNT_W-1:0]        cnt;          // FIFO level
    logic                    ov;           // Output valid
    beat_t                   ob;           // Output beat
    logic [CH_W-1:0]         och;          // Output slot index
    logic                    ofirst;       // Output group first
    logic                    olast;        // Output group last
    logic [1:0]              oerr;         // Output fault code
    fir_wrap_pkg::pkt_state_t pkt;         // Packet tracking
    logic [1:0]              last_err;     // Last fault, for software
    logic [31:0]             rdata;        // Read data register
  } state_t;

  // Whole state of the coefficient domain
  typedef struct packed {
    logic [NUM_COEF-1:0][COEF_W-1:0] mem;  // Tap store
    logic                            rv;   // Readback valid
    logic [COEF_W-1:0]               rd;   // Readback value
  } cstate_t;

  state_t  q;   // Main registers
  state_t  d;   // Main next state
  cstate_t cq;  // Coefficient registers
  cstate_t cd;  // Coefficient next state

  // Core gain stage: halve each lane, format chosen by software
  function automatic logic [BUS_W-1:0] core_gain(input logic [BUS_W-1:0] x,
                                                 input logic sgn);
    logic [BUS_W-1:0] y;
    y = '0;
    for (int l = 0; l < LANES; l++) begin
      // Lane l sits at bits l*DATA_W upward
      y[l*DATA_W +: DATA_W] = {sgn & x[l*DATA_W + DATA_W - 1],
                               x[l*DATA_W + 1 +: DATA_W - 1]};
    end
    return y;
  endfunction : core_gain

  // Ring pointer advance
  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction : ptr_inc

  logic             rdy;      // Consumer accept as seen by the block
  logic             adv;      // Core advance enable
  logic             cv;       // Core emits a result this cycle
  logic             load;     // Output register may take a new beat
  logic             push;     // Write into FIFO
  logic             pop;      // Read from FIFO
  logic             nv;       // Beat lands in output register
  beat_t            nb;       // Beat for output register
  logic             is_first; // Ordinal marks channel zero
  logic             is_last;  // Ordinal marks final channel

  // Next-state logic for the main domain
  always_comb begin
    d        = q;
    push     = 1'b0;
    pop      = 1'b0;
    nv       = 1'b0;
    nb       = q.pipe[CORE_LAT-1];
    is_first = 1'b0;
    is_last  = 1'b0;
    // Without backpressure support the consumer is taken as always ready
    rdy = (BACKPRESSURE != 0) ? source_ready_in : 1'b1;
    // Core advances only on a valid beat that is accepted
    adv = sink_valid_in & q.sink_ready;
    cv  = adv & q.pv[CORE_LAT-1];

    // Core pipeline: frozen unless advancing
    if (adv) begin
      for (int i = CORE_LAT - 1; i > 0; i--) begin
        d.pv[i]   = q.pv[i-1];
        d.pipe[i] = q.pipe[i-1];
      end
      d.pv[0]        = 1'b1;
      d.pipe[0].ord  = sink_ordinal_in;
      d.pipe[0].data = core_gain(sink_data_in, q.signed_mode);
    end

    // Output register takes a beat when empty or being taken
    load = ~q.ov | rdy;
    if (load) begin
      if (q.cnt != '0) begin  // FIFO has older results first
        nb   = q.mem[q.rp];
        nv   = 1'b1;
        pop  = 1'b1;
        push = cv;
      end else begin          // Straight from the core
        nb = q.pipe[CORE_LAT-1];
        nv = cv;
      end
      d.ov = nv;
    end else begin
      push = cv;              // Results still produced go to the FIFO
    end

    // Framing marks for the new output beat
    if (load && nv) begin
      is_first = (nb.ord == ORD_W'(1));
      is_last  = (nb.ord == ORD_W'(CHANS));
      d.ob     = nb;
      d.ofirst = is_first;
      d.olast  = is_last;
      d.och    = CH_W'(nb.ord - ORD_W'(1));
      // Fault code from ordinal and packet state
      if (nb.ord == '0 || nb.ord > ORD_W'(CHANS)) begin
        d.oerr = fir_wrap_pkg::ERR_OTHER;
      end else if (q.pkt == fir_wrap_pkg::PKT_IDLE && !is_first) begin
        d.oerr = fir_wrap_pkg::ERR_NO_START;
      end else if (q.pkt == fir_wrap_pkg::PKT_BUSY && is_first) begin
        d.oerr = fir_wrap_pkg::ERR_NO_END;
      end else begin
        d.oerr = fir_wrap_pkg::ERR_NONE;
      end
      // Packet opens on first, closes on last
      if (is_last) begin
        d.pkt = fir_wrap_pkg::PKT_IDLE;
      end else if (is_first) begin
        d.pkt = fir_wrap_pkg::PKT_BUSY;
      end
    end

    // FIFO bookkeeping
    if (push) begin
      d.mem[q.wp] = q.pipe[CORE_LAT-1];
      d.wp        = ptr_inc(q.wp);
    end
    if (pop) begin
      d.rp = ptr_inc(q.rp);
    end
    d.cnt = q.cnt + CNT_W'(push) - CNT_W'(pop);

    // Accept only while the FIFO can take one more and consumer accepts
    if (BACKPRESSURE != 0) begin
      d.sink_ready = rdy & (d.cnt < CNT_W'(DEPTH));
    end else begin
      d.sink_ready = 1'b1;  // Always accepting without backpressure
    end
    d.stall = ~rdy;

    // Register writes
    if (reg_wr_in && reg_addr_in == fir_wrap_pkg::REG_CTRL) begin
      d.signed_mode = reg_wdata_in[fir_wrap_pkg::CTRL_SIGNED_BIT];
    end
    if (reg_wr_in && reg_addr_in == fir_wrap_pkg::REG_STATUS) begin
      d.last_err = fir_wrap_pkg::ERR_RST;  // Write clears recorded fault
    end
    // New fault wins over a clear in the same cycle
    if (load && nv && d.oerr != fir_wrap_pkg::ERR_NONE) begin
      d.last_err = d.oerr;
    end

    // Register reads: data stands one cycle only
    d.rdata = '0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        fir_wrap_pkg::REG_CTRL: begin
          d.rdata[fir_wrap_pkg::CTRL_SIGNED_BIT] = q.signed_mode;
        end
        fir_wrap_pkg::REG_STATUS: begin
          d.rdata[fir_wrap_pkg::STAT_CNT_LSB +: CNT_W] = q.cnt;
          d.rdata[fir_wrap_pkg::STAT_PKT_BIT]          = q.pkt;
          d.rdata[fir_wrap_pkg::STAT_ERR_LSB +: 2]     = q.last_err;
        end
        fir_wrap_pkg::REG_INFO: begin
          d.rdata[fir_wrap_pkg::INFO_TDM_LSB +: 8]  = 8'(TDM);
          d.rdata[fir_wrap_pkg::INFO_CHAN_LSB +: 8] = 8'(CHANS);
          d.rdata[fir_wrap_pkg::INFO_LANE_LSB +: 8] = 8'(LANES);
        end
        default: begin
          d.rdata = '0;  // Unmapped reads as zero
        end
      endcase
    end
  end

  // Main registers, async active-low reset
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q             <= '0;
      q.signed_mode <= fir_wrap_pkg::CTRL_SIGNED_RST;
      q.pkt         <= fir_wrap_pkg::PKT_IDLE;
      q.last_err    <= fir_wrap_pkg::ERR_RST;
      q.sink_ready  <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from registers; data and slot free while valid low
  assign reg_rdata_out      = q.rdata;
  assign sink_ready_out     = q.sink_ready;
  assign source_valid_out   = q.ov;
  assign lane_result_out    = q.ob.data;
  assign source_channel_out = q.och;
  assign source_first_out   = q.ofirst;
  assign source_last_out    = q.olast;
  assign source_error_out   = q.oerr;
  assign source_stall_out   = q.stall;
  assign coef_rvalid_out    = cq.rv;
  assign coef_rdata_out     = cq.rd;

  // Coefficient port next state: write or read back at the tap index
  always_comb begin
    cd    = cq;
    cd.rv = 1'b0;
    if (coef_we_in) begin
      if (32'(coef_addr_in) < NUM_COEF) begin
        cd.mem[coef_addr_in] = coef_data_in;
      end
    end else begin
      cd.rv = 1'b1;
      cd.rd = (32'(coef_addr_in) < NUM_COEF) ? cq.mem[coef_addr_in] : '0;
    end
  end

  // Coefficient registers on their own clock, async active-high reset
  always_ff @(posedge coef_clk_in or posedge coef_rst_in) begin
    if (coef_rst_in) begin
      cq <= '0;
    end else begin
      cq <= cd;
    end
  end

  // Sequences used by the checks below
  sequence s_held_beat;
    source_valid_out && !source_ready_in;
  endsequence

  sequence s_tap_write_read;
    coef_we_in ##1 (!coef_we_in && coef_addr_in == $past(coef_addr_in));
  endsequence

  // Beat not taken stays unchanged until accepted
  a_hold_output: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (BACKPRESSURE != 0) and s_held_beat |=>
      source_valid_out && $stable(lane_result_out) && $stable(source_channel_out))
    else $error("output beat changed while not accepted");

  // Refusing consumer withdraws input accept next cycle
  a_accept_drop: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (BACKPRESSURE != 0) && !source_ready_in |=> !sink_ready_out)
    else $error("input accept stayed high under backpressure");

  // Stall output follows refusal one cycle later
  a_stall_level: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (BACKPRESSURE != 0) |-> ##1 (source_stall_out == !$past(source_ready_in)))
    else $error("stall does not follow consumer accept");

  // Accept returns the cycle after consumer accepts with the FIFO empty
  a_resume_fast: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    source_ready_in && q.cnt == '0 |=> sink_ready_out)
    else $error("core not re-enabled after consumer recovered");

  // Idle input freezes the core pipeline
  a_core_freeze: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    !sink_valid_in |=> $stable(q.pipe) && $stable(q.pv))
    else $error("core moved without input valid");

  // FIFO never overflows
  a_fifo_bound: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    q.cnt <= CNT_W'(DEPTH))
    else $error("source FIFO overflow");

  // Group first means slot zero, group last means final slot
  a_first_slot: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    source_valid_out && source_first_out |-> source_channel_out == '0)
    else $error("group first not on slot zero");

  a_last_slot: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    source_valid_out && source_last_out |-> source_channel_out == CH_W'(CHANS - 1))
    else $error("group last not on final slot");

  // Beat loaded between packets with an in-range ordinal other than one reports missing start
  a_err_no_start: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    load && nv && q.pkt == fir_wrap_pkg::PKT_IDLE && nb.ord != ORD_W'(1) &&
    nb.ord != '0 && nb.ord <= ORD_W'(CHANS) |=>
      source_error_out == fir_wrap_pkg::ERR_NO_START)
    else $error("missing start not reported");

  // Ordinal one inside an open packet reports missing end
  a_err_no_end: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    load && nv && q.pkt == fir_wrap_pkg::PKT_BUSY && nb.ord == ORD_W'(1) |=>
      source_error_out == fir_wrap_pkg::ERR_NO_END)
    else $error("missing end not reported");

  // Input accept is never offered while stall is raised
  a_accept_stall: assert property (
    @(posedge ref_clk_in) disable iff (!nrst_in)
    (BACKPRESSURE != 0) && source_stall_out |-> !sink_ready_out)
    else $error("input accept raised during stall");

  // Written tap reads back on the next read
  a_tap_readback: assert property (
    @(posedge coef_clk_in) disable iff (coef_rst_in)
    s_tap_write_read |=> coef_rvalid_out && coef_rdata_out == $past(coef_data_in, 2))
    else $error("tap readback mismatch");

endmodule : fir_stream_wrapper

/* fir_far_consumer.sv */
// Downstream consumer model that paces the source accept line
`timescale 1ns/1ns
module fir_far_consumer (
  input  wire logic       ref_clk_in, // Main clock
  input  wire logic       nrst_in,    // Async reset, low
  input  wire logic [1:0] mode_in,    // 0 prompt, 1 slow, 2 refusing
  output logic            ready_out   // Accept toward the block
);
  logic [1:0] phase_q;  // Slow-mode cycle position

  // Accept changes only just after a rising edge
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_q   <= 2'h0;
      ready_out <= 1'b0;
    end else begin
      phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
      case (mode_in)
        2'h0:    ready_out <= 1'b1;               // Always ready, as if tied
        2'h1:    ready_out <= (phase_q == 2'h0);  // Takes one beat in three
        default: ready_out <= 1'b0;               // Refuses everything
      endcase
    end
  end
endmodule : fir_far_consumer

/* fir_stream_wrapper_tb.sv */
// Self-checking bench for the streaming filter wrapper
`timescale 1ns/1ns
module fir_stream_wrapper_tb;
  localparam int LANES = 1;  // Output lanes
  localparam int CHANS = 2;  // Channels per lane
  localparam int TDM   = fir_wrap_pkg::CLK_MHZ / fir_wrap_pkg::SAMPLE_MSPS;  // Slots per lane
  typedef struct packed {
    logic [7:0] data;  // Sample offered
    logic [2:0] ord;   // Beat ordinal
    logic [7:0] res;   // Expected result
    logic [1:0] err;   // Expected framing fault
  } beat_row_t;
  // Beats with expected results; rows 9 on run in signed format
  localparam beat_row_t ROWS [13] = '{
    '{8'hF0, 3'h1, 8'h78, 2'h0}, '{8'h0F, 3'h2, 8'h07, 2'h0}, '{8'h22, 3'h2, 8'h11, 2'h1},
    '{8'h44, 3'h1, 8'h22, 2'h0}, '{8'h66, 3'h1, 8'h33, 2'h2}, '{8'h08, 3'h2, 8'h04, 2'h0},
    '{8'h10, 3'h0, 8'h08, 2'h3}, '{8'h30, 3'h1, 8'h18, 2'h0}, '{8'h52, 3'h2, 8'h29, 2'h0},
    '{8'h80, 3'h1, 8'hC0, 2'h0}, '{8'hF3, 3'h2, 8'hF9, 2'h0}, '{8'h7E, 3'h1, 8'h3F, 2'h0},
    '{8'h02, 3'h2, 8'h01, 2'h0}};

  logic        ref_clk_in = 1'b0, nrst_in = 1'b0, coef_clk_in = 1'b0, coef_rst_in = 1'b1;
  logic [3:0]  reg_addr_in = 4'h0;      // Register address
  logic [31:0] reg_wdata_in = 32'h0;    // Register write data
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;           // Register read data
  logic        sink_valid_in = 1'b0;    // Producer valid
  logic [7:0]  sink_data_in = 8'h0;     // Producer sample
  logic [2:0]  sink_ordinal_in = 3'h0;  // Producer ordinal
  logic        sink_ready_out, source_ready_in, source_valid_out;
  logic        source_first_out, source_last_out, source_stall_out, coef_rvalid_out;
  logic [7:0]  lane_result_out;         // Result bus
  logic [0:0]  source_channel_out;      // Slot index
  logic [1:0]  source_error_out;        // Framing fault
  logic [1:0]  mode = 2'h0;             // Consumer pacing
  logic [2:0]  coef_addr_in = 3'h0;     // Tap index
  logic        coef_we_in = 1'b0;       // Tap write strobe
  logic [15:0] coef_data_in = 16'h0, coef_rdata_out;
  beat_row_t   exp_q [$];               // Beats awaiting their result
  beat_row_t   r;                       // Beat being compared
  logic        prev_rdy;                // Consumer accept one cycle back
  int          cyc = 0, miscompares = 0, n_checks = 0;

  always #5 ref_clk_in = ~ref_clk_in;     // 100 MHz main clock
  always #17 coef_clk_in = ~coef_clk_in;  // Slower coefficient clock

  fir_stream_wrapper #(.DATA_W(8), .LANES(LANES), .CHANS(CHANS)) DUT (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .sink_valid_in(sink_valid_in), .sink_data_in(sink_data_in),
    .sink_ordinal_in(sink_ordinal_in), .sink_ready_out(sink_ready_out),
    .source_ready_in(source_ready_in), .source_valid_out(source_valid_out),
    .lane_result_out(lane_result_out), .source_channel_out(source_channel_out),
    .source_first_out(source_first_out), .source_last_out(source_last_out),
    .source_error_out(source_error_out), .source_stall_out(source_stall_out),
    .coef_clk_in(coef_clk_in), .coef_rst_in(coef_rst_in), .coef_addr_in(coef_addr_in),
    .coef_we_in(coef_we_in), .coef_data_in(coef_data_in), .coef_rvalid_out(coef_rvalid_out),
    .coef_rdata_out(coef_rdata_out));

  fir_far_consumer far (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .mode_in(mode),
    .ready_out(source_ready_in));

  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Print counts and verdict, then stop
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  // One-cycle register write
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask : reg_wr

  // One-cycle register read, data checked in the following cycle
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("register", d, reg_rdata_out);
  endtask : reg_rd

  // Offer a beat and hold it until accepted; valid stays up afterwards
  task automatic send(input beat_row_t b);
    int n;
    sink_data_in    <= b.data;
    sink_ordinal_in <= b.ord;
    sink_valid_in   <= 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (sink_ready_out !== 1'b1 && n < 300);
    if (n >= 300) begin
      chk("accept wait", 1, 0);
      finish_test();
    end
    exp_q.push_back(b);
    @(posedge ref_clk_in);
  endtask : send

  // Withdraw valid; data lines show a changed value
  task automatic idle;
    sink_valid_in <= 1'b0;
    sink_data_in  <= ~sink_data_in;
    @(posedge ref_clk_in);
  endtask : idle

  // Tap write; strobe is left high for back-to-back writes
  task automatic coef_wr(input logic [2:0] a, input logic [15:0] d);
    coef_addr_in <= a;
    coef_data_in <= d;
    coef_we_in   <= 1'b1;
    @(posedge coef_clk_in);
  endtask : coef_wr

  // Tap read with its valid flag
  task automatic coef_rd(input logic [2:0] a, input logic [15:0] d);
    coef_we_in   <= 1'b0;
    coef_addr_in <= a;
    @(posedge coef_clk_in);
    #1;
    chk("tap", {1'b1, d}, {coef_rvalid_out, coef_rdata_out});
  endtask : coef_rd

  // Result scoreboard and stall follower, sampled mid-cycle
  always @(negedge ref_clk_in) begin
    cyc = nrst_in ? cyc + 1 : 0;
    if (cyc > 1) chk("stall", !prev_rdy, source_stall_out);
    prev_rdy = source_ready_in;
    if (nrst_in && source_valid_out === 1'b1 && source_ready_in === 1'b1) begin
      if (exp_q.size() == 0) chk("spare beat", 0, 1);
      else begin
        r = exp_q.pop_front();
        chk("result", r.res, lane_result_out);
        chk("error", r.err, source_error_out);
        chk("first", r.ord == 3'h1, source_first_out);
        chk("last", r.ord == 3'h2, source_last_out);
        if (r.err != 2'h3) chk("channel", r.ord - 3'h1, source_channel_out);
      end
    end
  end

  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk("reset", 0, {sink_ready_out, source_valid_out, coef_rvalid_out});
    @(posedge ref_clk_in);
    nrst_in     <= 1'b1;
    coef_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    reg_rd(fir_wrap_pkg::REG_CTRL, 32'h0);
    reg_rd(fir_wrap_pkg::REG_INFO, {8'h0, 8'(LANES), 8'(CHANS), 8'(TDM)});
    reg_rd(4'hC, 32'h0);
    mode <= 2'h1;
    for (int i = 0; i < 13; i++) begin
      if (i == 9) begin
        idle();
        reg_wr(fir_wrap_pkg::REG_CTRL, 32'h1);
      end
      send(ROWS[i]);
    end
    idle();
    mode <= 2'h2;
    repeat (8) @(posedge ref_clk_in);
    #1;
    chk("stalled", 2'h1, {sink_ready_out, source_stall_out});
    mode <= 2'h0;
    repeat (3) @(posedge ref_clk_in);
    #1;
    chk("resumed", 1, sink_ready_out);
    send('{8'h00, 3'h1, 8'h00, 2'h0});
    send('{8'h00, 3'h2, 8'h00, 2'h0});
    idle();
    repeat (10) @(posedge ref_clk_in);
    chk("pending", 2, exp_q.size());
    // Last recorded fault is the bad ordinal; a status write clears it
    reg_rd(fir_wrap_pkg::REG_STATUS, 32'h3000);
    reg_wr(fir_wrap_pkg::REG_STATUS, 32'h0);
    reg_rd(fir_wrap_pkg::REG_STATUS, 32'h0);
    @(posedge coef_clk_in);
    coef_rd(3'h5, 16'h0);
    for (int t = 0; t < 8; t++) coef_wr(3'(t), 16'hA500 + 16'(t));
    // Read back from the last tap down, so the first read follows its own write
    for (int t = 0; t < 8; t++) coef_rd(3'(7 - t), 16'hA507 - 16'(t));
    coef_rst_in <= 1'b1;
    @(posedge coef_clk_in);
    #1;
    chk("tap reset", 0, coef_rvalid_out);
    coef_rst_in <= 1'b0;
    coef_rd(3'h3, 16'h0);
    finish_test();
  end
endmodule : fir_stream_wrapper_tb
